// ---- rtl/serial_dac_pkg.sv ----
// Package: shared constants for the serial DAC loader link.
// Assumes both ends and the bench refer to names as serial_dac_pkg::name.
package serial_dac_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int SHIFT_W   = 16;   // Input shift register width
    localparam int CODE_W    = 10;   // DAC code width
    localparam int SUB_W     = 2;    // Sub-LSB bits
    localparam int LATCH_W   = 12;   // Code plus sub-LSB bits
    localparam int DUMMY_W   = 4;    // Upper dummy bits of long frame
    localparam int FULL_SCALE = 1024; // Code divisor of output
    localparam logic [CODE_W-1:0] DAC_RESET = 10'h000; // Power-up code
    localparam logic [CODE_W-1:0] MID_SCALE = 10'h200; // Half of reference
    // ----------------------------------------------------------------
    // Link timing
    // ----------------------------------------------------------------
    localparam int MCLK_NS   = 100;  // Host clock period
    localparam int LINK_HALF_NS = 100; // Least half period of link clock
    localparam int HALF_CYC  = (LINK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int GAP_CYC   = 2;    // Gap ends at this count, so the gap state lasts one host clock more
endpackage : serial_dac_pkg

// ---- rtl/serial_dac_if.sv ----
// Interface: three-wire serial link plus chain output.
// Assumes the host end drives clock, select and data; device drives chain.
interface serial_dac_if;
    logic sclk;        // Serial clock made by host
    logic sel_n;       // Frame select, active low
    logic serial_in;   // Data from host
    logic chain_out;   // Chained data from device
    modport host   (output sclk, output sel_n, output serial_in, input chain_out);
    modport device (input sclk, input sel_n, input serial_in, output chain_out);
endinterface : serial_dac_if

// ---- rtl/serial_dac_device.sv ----
// Device end: shift register, DAC register and chain output.
// Assumes link clock and select rising edge are the only clocks; the reset models power-up.
module serial_dac_device (
    // Link
    serial_dac_if.device                              link,
    // Power-up reset
    input  wire logic                                 reset_n_i,
    // DAC side
    output logic [serial_dac_pkg::CODE_W-1:0]         dac_code_o,
    output logic [serial_dac_pkg::SUB_W-1:0]          dac_sub_o
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [serial_dac_pkg::SHIFT_W-1:0] shift_reg;  // Input shift register
    logic                               chain_reg;  // Chain output bit
    // Shift on rising link clock while selected; select high is an enable
    // term that blocks the shift, so clock edges are ignored and nothing shifts then.
    always_ff @(posedge link.sclk or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_reg <= '0;
        end else if (!link.sel_n) begin
            shift_reg <= {shift_reg[serial_dac_pkg::SHIFT_W-2:0], link.serial_in};
        end
    end
    // Chain bit updates on falling edges only while selected
    always_ff @(negedge link.sclk or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chain_reg <= 1'b0;
        end else if (!link.sel_n) begin
            chain_reg <= shift_reg[serial_dac_pkg::SHIFT_W-1];
        end
    end
    assign link.chain_out = chain_reg;
    // Select rising edge loads code and sub-LSB bits; earlier bits dropped
    always_ff @(posedge link.sel_n or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dac_code_o <= serial_dac_pkg::DAC_RESET;
            dac_sub_o  <= '0;
        end else begin
            dac_code_o <= shift_reg[serial_dac_pkg::LATCH_W-1:serial_dac_pkg::SUB_W];
            dac_sub_o  <= shift_reg[serial_dac_pkg::SUB_W-1:0];
        end
    end
endmodule : serial_dac_device

// ---- rtl/serial_dac_host.sv ----
// Host end: serial master making the link clock from mclk_i by a divider.
// Assumes a one-cycle write request with a code; ready shows idle, one host clock late.
// Assumes wr_i, code_i and long_frame_i come from logic on mclk_i.
// Assumes the device end is clocked only by the link clock and select made here.
module serial_dac_host #(
    parameter int HALF = serial_dac_pkg::HALF_CYC  // mclk cycles per link half period
) (
    // Clock and reset
    input  wire logic                                 mclk_i,
    input  wire logic                                 reset_n_i,
    // User request
    input  wire logic                                 wr_i,
    input  wire logic [serial_dac_pkg::CODE_W-1:0]    code_i,
    input  wire logic                                 long_frame_i,
    output logic                                      ready_o,
    output logic                                      done_o,
    output logic [serial_dac_pkg::SHIFT_W-1:0]        echo_o,
    // Link
    serial_dac_if.host                                link
);
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Idle, clock-low half, clock-high half, select-high gap after a frame
    typedef enum logic [1:0] {IDLE, LOW, HIGH, GAP} state_t;
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    state_t                             state_reg;  // Frame state
    logic [7:0]                         div_reg;    // Half-period counter
    logic [4:0]                         bits_reg;   // Bits left
    logic [serial_dac_pkg::SHIFT_W-1:0] tx_reg;     // Outgoing word
    logic [serial_dac_pkg::SHIFT_W-1:0] rx_reg;     // Returned chain bits
    logic                               sclk_reg;   // Link clock out
    logic                               sel_n_reg;  // Select out
    logic                               dat_reg;    // Data out
    logic                               ch_m, ch_s; // Chain synchroniser
    // ----------------------------------------------------------------
    // Strobes
    // ----------------------------------------------------------------
    logic                               take;       // Request accepted now
    logic                               half_end;   // Last cycle of a half period
    logic                               gap_end;    // Last cycle of the gap
    logic [serial_dac_pkg::SHIFT_W-1:0] load_word;  // Word to send, MSB first
    logic [4:0]                         load_bits;  // Clock rises in the frame
    logic                               first_bit;  // Bit shown before first rise
    // A request counts only while idle and showing ready
    assign take      = (state_reg == IDLE) && wr_i && ready_o;
    // Divider compares; the casts keep them at counter width
    assign half_end  = (div_reg == 8'(HALF - 1));
    assign gap_end   = (div_reg == 8'(serial_dac_pkg::GAP_CYC));
    // Long frame: four dummies first; short: twelve bits only
    assign load_word = long_frame_i
        ? {{serial_dac_pkg::DUMMY_W{1'b0}}, code_i, {serial_dac_pkg::SUB_W{1'b0}}}
        : {code_i, {serial_dac_pkg::SUB_W{1'b0}}, {serial_dac_pkg::DUMMY_W{1'b0}}};
    // The whole word goes in a long frame; a short frame sends its upper twelve bits
    assign load_bits = long_frame_i
        ? 5'(serial_dac_pkg::SHIFT_W)
        : 5'(serial_dac_pkg::LATCH_W);
    // The first bit stands one link half period before the first rise
    assign first_bit = load_word[serial_dac_pkg::SHIFT_W-1];
    // ----------------------------------------------------------------
    // Chain input
    // ----------------------------------------------------------------
    // Two-flop synchroniser: the chain bit moves on the link clock
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ch_m <= 1'b0;
            ch_s <= 1'b0;
        end else begin
            ch_m <= link.chain_out;
            ch_s <= ch_m;
        end
    end
    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    // State walks idle, then low and high halves per bit, then the gap
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= IDLE;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    // Start a frame on an accepted request
                    if (take) begin
                        state_reg <= LOW;
                    end
                end
                LOW: begin
                    // End of clock-low half raises the clock
                    if (half_end) begin
                        state_reg <= HIGH;
                    end
                end
                HIGH: begin
                    // End of clock-high half: next bit or the gap
                    if (half_end) begin
                        state_reg <= (bits_reg == 5'h00) ? GAP : LOW;
                    end
                end
                GAP: begin
                    // Gap over: back to idle
                    if (gap_end) begin
                        state_reg <= IDLE;
                    end
                end
            endcase
        end
    end
    // Divider counts within each half period and across the gap
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_reg <= '0;
        end else if (take) begin
            div_reg <= '0;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    // Hold while waiting
                    div_reg <= div_reg;
                end
                LOW, HIGH: begin
                    // Wrap at the end of each half
                    div_reg <= half_end ? 8'h00 : div_reg + 8'h01;
                end
                GAP: begin
                    // Wrap at the end of the gap
                    div_reg <= gap_end ? 8'h00 : div_reg + 8'h01;
                end
            endcase
        end
    end
    // Bit counter: loaded on take, one less at every rise
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bits_reg <= '0;
        end else if (take) begin
            bits_reg <= load_bits;
        end else if (state_reg == LOW && half_end) begin
            bits_reg <= bits_reg - 5'h01;
        end
    end
    // Outgoing word: loaded on take, shifted at every rise
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_reg <= '0;
        end else if (take) begin
            tx_reg <= load_word;
        end else if (state_reg == LOW && half_end) begin
            tx_reg <= {tx_reg[serial_dac_pkg::SHIFT_W-2:0], 1'b0};
        end
    end
    // Data changes only with the clock falling or before the first rise,
    // so it never moves at the edge that the device samples
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dat_reg <= 1'b0;
        end else if (take) begin
            dat_reg <= first_bit;
        end else if (state_reg == HIGH && half_end) begin
            // Word was shifted at the rise: its MSB is the next bit
            dat_reg <= tx_reg[serial_dac_pkg::SHIFT_W-1];
        end
    end
    // Link clock: low while idle, toggled at the end of each half
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_reg <= 1'b0;
        end else if (state_reg == IDLE) begin
            sclk_reg <= 1'b0;
        end else if (state_reg == LOW && half_end) begin
            sclk_reg <= 1'b1;
        end else if (state_reg == HIGH && half_end) begin
            sclk_reg <= 1'b0;
        end
    end
    // Select falls on take and rises in the gap, both with clock low
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_n_reg <= 1'b1;
        end else if (take) begin
            sel_n_reg <= 1'b0;
        end else if (state_reg == GAP) begin
            sel_n_reg <= 1'b1;
        end
    end
    // Returned chain bits taken as the clock falls
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_reg <= '0;
        end else if (state_reg == HIGH && half_end) begin
            rx_reg <= {rx_reg[serial_dac_pkg::SHIFT_W-2:0], ch_s};
        end
    end
    // ----------------------------------------------------------------
    // User side
    // ----------------------------------------------------------------
    // Ready from the second idle cycle on (registered, so one cycle late); dropped at the take
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ready_o <= 1'b0;
        end else if (state_reg == IDLE) begin
            ready_o <= !take;
        end
    end
    // Done pulses for one cycle as the gap ends
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (state_reg == GAP) && gap_end;
        end
    end
    // Echo shows the chain bits of the finished frame
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            echo_o <= '0;
        end else if (state_reg == GAP && gap_end) begin
            echo_o <= rx_reg;
        end
    end
    // ----------------------------------------------------------------
    // Link pins
    // ----------------------------------------------------------------
    // All straight from registers
    assign link.sclk      = sclk_reg;
    assign link.sel_n     = sel_n_reg;
    assign link.serial_in = dat_reg;
endmodule : serial_dac_host

// ---- verif/serial_dac_loader_chk.sv ----
// Checker: link rules watched at the host clock.
// Assumes link signals change only at host clock edges.
module serial_dac_loader_chk (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    // Link
    input  wire logic sclk,
    input  wire logic sel_n,
    input  wire logic serial_in,
    input  wire logic chain_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------------
    logic [4:0]  rise_cnt; // Clock rises in this frame
    logic [15:0] hist;     // Bits taken at rises, newest low
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // Count rises, cleared while select is high
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) rise_cnt <= 5'h00;
        else if (sel_n) rise_cnt <= 5'h00;
        else if ($rose(sclk)) rise_cnt <= rise_cnt + 5'h01;
    end
    // Keep the bits the device should be holding
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) hist <= 16'h0000;
        else if ($rose(sclk) && !sel_n) hist <= {hist[14:0], serial_in};
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_sel_clk_low: assert property (
        $changed(sel_n) |-> !sclk && !$past(sclk)) else $error("select moved, clock high");
    a_idle_clk_low: assert property (
        sel_n |-> !sclk) else $error("clock high while idle");
    a_data_steady: assert property (
        sclk |-> $stable(serial_in)) else $error("data moved while clock high");
    a_frame_len: assert property (
        $rose(sel_n) |-> rise_cnt == 5'd12 || rise_cnt == 5'd16) else $error("bad frame length");
    a_sub_zero: assert property (
        $rose(sel_n) |-> hist[1:0] == 2'b00) else $error("trailing bits not zero");
    a_rise_limit: assert property (
        !sel_n |-> rise_cnt <= 5'd16) else $error("frame longer than register");
    a_chain_fall: assert property (
        $changed(chain_out) |-> $fell(sclk) && !sel_n) else $error("chain moved off edge");
    a_chain_delay: assert property (
        $fell(sclk) |-> chain_out == hist[15]) else $error("chain bit wrong");
endmodule : serial_dac_loader_chk

// ---- verif/serial_dac_loader_tb.sv ----
// Testbench: host and device joined by the link, random codes.
// Assumes the host makes the link clock from mclk_i.
module serial_dac_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                                mclk_i, reset_n_i, wr_i;
    logic                                long_frame_i, ready_o, done_o;
    logic [serial_dac_pkg::CODE_W-1:0]   code_i, dac_code_o;
    logic [serial_dac_pkg::SUB_W-1:0]    dac_sub_o;
    logic [serial_dac_pkg::SHIFT_W-1:0]  echo_o;
    logic [63:0]                         s_hist;     // Last 64 bits sent
    int                                  fail_count, n_checks, cyc;
    int                                  seed = 32'hCF1FA8F7;
    serial_dac_if u_serial_dac_if ();
    serial_dac_host #(.HALF(2)) u_serial_dac_host (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .wr_i(wr_i), .code_i(code_i), .long_frame_i(long_frame_i),
        .ready_o(ready_o), .done_o(done_o), .echo_o(echo_o), .link(u_serial_dac_if.host));
    serial_dac_device u_serial_dac_device (.link(u_serial_dac_if.device),
        .reset_n_i(reset_n_i), .dac_code_o(dac_code_o), .dac_sub_o(dac_sub_o));
    serial_dac_loader_chk u_serial_dac_loader_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .sclk(u_serial_dac_if.sclk), .sel_n(u_serial_dac_if.sel_n),
        .serial_in(u_serial_dac_if.serial_in), .chain_out(u_serial_dac_if.chain_out));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // One write, then the latched code and, after a long frame only, the chain echo
    task automatic send(input logic [serial_dac_pkg::CODE_W-1:0] c, input logic lf);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 300) begin
            @(negedge mclk_i);
            n++;
        end
        @(posedge mclk_i);
        wr_i <= 1'b1;
        code_i <= c;
        long_frame_i <= lf;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 300) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 300) fail_count++;
        // Short frames carry no dummy bits
        if (lf) s_hist = {s_hist[47:0], 4'h0, c, 2'b00};
        else s_hist = {s_hist[51:0], c, 2'b00};
        chk(16'(dac_code_o), 16'(s_hist[11:2]));
        chk(16'(dac_sub_o), 16'h0000);
        if (lf) chk(echo_o, s_hist[31:16]);
    endtask : send
    // ----------------------------------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // Cut a hang short
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            report_and_stop;
        end
    end
    initial begin
        reset_n_i = 1'b0;
        wr_i = 1'b0;
        code_i = 10'h000;
        long_frame_i = 1'b0;
        s_hist = 64'h0;
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(negedge mclk_i);
        chk(16'(dac_code_o), 16'h0000);
        send(10'h200, 1'b1);
        send(10'h3FF, 1'b0);
        send(10'h000, 1'b1);
        for (int i = 0; i < 20; i++) begin
            send(10'($random(seed)), i[0]);
        end
        report_and_stop;
    end
endmodule : serial_dac_loader_tb
